// File: uec_params.svh
`ifndef UEC_PARAMS_SVH
`define UEC_PARAMS_SVH

// Read addresses
`define UEC_RD_EP0_SCRATCH 8'hF2
`define UEC_RD_EP0_STATUS  8'hF3
`define UEC_RD_EP2_CONTROL 8'hF4
`define UEC_RD_EP2_TOGGLE  8'hF5
`define UEC_RD_EP2_MAXPKT  8'hF6

// Write addresses
`define UEC_WR_EP0_SCRATCH 8'h72
`define UEC_WR_EP0_STATUS  8'h73
`define UEC_WR_EP2_CONTROL 8'h74
`define UEC_WR_EP2_TOGGLE  8'h75
`define UEC_WR_EP2_MAXPKT  8'h76

// Endpoint 0 status fields
`define UEC_EP0_READY_BIT  0
`define UEC_EP0_STALL_BIT  2
`define UEC_EP0_STAGE_LSB  3

// Endpoint 2 control and toggle fields
`define UEC_EP2_CFG_BIT    7
`define UEC_EP2_STALL_BIT  1
`define UEC_EP2_DIR_BIT    0
`define UEC_EP2_FIXED      5'h0A
`define UEC_TGL_RESET_BIT  0

// Endpoint numbers and sizes
`define UEC_EP0_NUM        4'h0
`define UEC_EP2_NUM        4'h2
`define UEC_EP0_MAX_SIZE   7'h08
`define UEC_CNT_SAT        7'h7F

// Reset values
`define UEC_SCRATCH_RST    7'h00
`define UEC_EP2_MAXPKT_RST 7'h40

`endif

// File: uec_pkg.sv
package uec_pkg;

    typedef enum logic [1:0] {
        UEC_STG_SETUP,
        UEC_STG_DATA,
        UEC_STG_STATUS
    } uec_stage_t;

    typedef enum logic [1:0] {
        UEC_HS_ACK,
        UEC_HS_NAK,
        UEC_HS_STALL
    } uec_hs_t;

endpackage

// File: uec_ep0_ctrl.sv
`include "uec_params.svh"

module uec_ep0_ctrl
    import uec_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic bus_rst,
    // USB events
    input  wire logic setup_tok,
    input  wire logic setup_ok,
    input  wire logic has_data,
    input  wire logic dir_in,
    input  wire logic in_tok,
    input  wire logic out_tok,
    input  wire logic rx_accept,
    input  wire logic stall_set_hw,
    // Register writes
    input  wire logic ready_clr_wr,
    input  wire logic stall_set_wr,
    // State
    output logic       setup_ready_reg,
    output logic       stall_reg,
    output uec_stage_t stage_reg,
    output logic       lock_reg,
    output logic       pkt_ready_reg,
    output logic       rd_dir_reg
);

    logic clr_n;
    assign clr_n = rst_n && !bus_rst;

    // A new setup wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!clr_n) begin
            setup_ready_reg <= 1'b0;
        end else if (setup_ok) begin
            setup_ready_reg <= 1'b1;
        end else if (ready_clr_wr) begin
            setup_ready_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!clr_n) begin
            lock_reg <= 1'b0;
        end else if (setup_ok) begin
            lock_reg <= 1'b1;
        end else if (ready_clr_wr) begin
            lock_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!clr_n) begin
            pkt_ready_reg <= 1'b0;
        end else if (rx_accept) begin
            pkt_ready_reg <= 1'b1;
        end else if (setup_ok || (ready_clr_wr && !rd_dir_reg)) begin
            pkt_ready_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!clr_n) begin
            stall_reg <= 1'b0;
        end else if (stall_set_wr || stall_set_hw) begin
            stall_reg <= 1'b1;
        end else if (setup_tok) begin
            stall_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!clr_n) begin
            rd_dir_reg <= 1'b0;
        end else if (setup_ok) begin
            rd_dir_reg <= dir_in;
        end
    end

    always_ff @(posedge clk) begin
        if (!clr_n) begin
            stage_reg <= UEC_STG_SETUP;
        end else if (setup_tok) begin
            stage_reg <= UEC_STG_SETUP;
        end else if (setup_ok) begin
            stage_reg <= has_data ? UEC_STG_DATA : UEC_STG_STATUS;
        end else begin
            case (stage_reg)
                UEC_STG_DATA: begin
                    if ((rd_dir_reg && out_tok) || (!rd_dir_reg && in_tok)) begin
                        stage_reg <= UEC_STG_STATUS;
                    end
                end
                default: begin
                    stage_reg <= stage_reg;
                end
            endcase
        end
    end

endmodule

// File: uec_ep2_bulk.sv
`include "uec_params.svh"

module uec_ep2_bulk (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       bus_rst,
    // Register writes
    input  wire logic       ctl_wr,
    input  wire logic       tgl_wr,
    input  wire logic       pld_wr,
    input  wire logic [7:0] wdata,
    // USB events
    input  wire logic       stall_hw,
    input  wire logic       flip,
    // State
    output logic            cfg_reg,
    output logic            stall_reg,
    output logic            dir_reg,
    output logic            toggle_reg,
    output logic [6:0]      pld_reg
);

    logic clr_n;
    assign clr_n = rst_n && !bus_rst;

    always_ff @(posedge clk) begin
        if (!clr_n) begin
            cfg_reg <= 1'b0;
            dir_reg <= 1'b0;
        end else if (ctl_wr) begin
            cfg_reg <= wdata[`UEC_EP2_CFG_BIT];
            dir_reg <= wdata[`UEC_EP2_DIR_BIT];
        end
    end

    // Hardware stall wins over a software write of zero
    always_ff @(posedge clk) begin
        if (!clr_n) begin
            stall_reg <= 1'b0;
        end else if (stall_hw) begin
            stall_reg <= 1'b1;
        end else if (ctl_wr) begin
            stall_reg <= wdata[`UEC_EP2_STALL_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!clr_n) begin
            toggle_reg <= 1'b0;
        end else if (tgl_wr && wdata[`UEC_TGL_RESET_BIT]) begin
            toggle_reg <= 1'b0;
        end else if (flip) begin
            toggle_reg <= !toggle_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (!clr_n) begin
            pld_reg <= `UEC_EP2_MAXPKT_RST;
        end else if (pld_wr) begin
            pld_reg <= wdata[6:0];
        end
    end

endmodule

// File: uec_ep_ctrl_top.sv
`include "uec_params.svh"

module uec_ep_ctrl_top
    import uec_pkg::*;
(
    // Clock and reset
    input  wire logic       CLK,
    input  wire logic       RESET_N,
    input  wire logic       USB_BUS_RESET,
    // Microcontroller bus
    input  wire logic       CS_N,
    input  wire logic       RD_N,
    input  wire logic       WR_N,
    input  wire logic [7:0] ADDR,
    input  wire logic [7:0] DATA_IN,
    output logic      [7:0] DATA_OUT,
    output logic            DATA_OE,
    // Interrupt
    input  wire logic       SETUP_INT_EN,
    output logic            IRQ_OUT_N_N,
    // Tokens from the protocol engine
    input  wire logic       TOK_SETUP,
    input  wire logic       TOK_IN,
    input  wire logic       TOK_OUT,
    input  wire logic [3:0] TOK_EP,
    // Setup packet result
    input  wire logic       SETUP_OK,
    input  wire logic       SETUP_HAS_DATA,
    input  wire logic       SETUP_DIR_IN,
    // OUT data packet
    input  wire logic       RX_BYTE,
    input  wire logic       RX_EOP,
    input  wire logic       RX_NO_EOP,
    // IN data packet acknowledged by the host
    input  wire logic       TX_ACKED,
    // Handshake request
    output logic            HS_VALID,
    output logic      [1:0] HS_CODE,
    // Status
    output logic            EP0_PKT_READY,
    output logic            EP0_RX_LOCKED,
    output logic            EP2_RX_PKT_READY,
    output logic            EP2_IN_GRANT,
    output logic            EP2_TOGGLE
);

    // Bus interface
    logic       wr_act;
    logic       wr_prev_reg;
    logic       wr_stb;
    logic       wr_scratch;
    logic       wr_ep0;
    logic       wr_ep2c;
    logic       wr_tgl;
    logic       wr_pld;
    logic       rd_act;
    logic [7:0] rd_data;
    logic [7:0] data_out_reg;
    logic       data_oe_reg;
    logic [6:0] scratch_reg;

    // Transaction tracking
    logic [3:0] cur_ep_reg;
    logic       cur_out_reg;
    logic [6:0] cnt_reg;
    logic       ep0_over;
    logic       ep2_over;
    logic       ep0_ctl_wr_data;
    logic       ep2_on;

    // Handshake and events
    logic       hs_valid_next;
    uec_hs_t    hs_code_next;
    logic       hs_valid_reg;
    uec_hs_t    hs_code_reg;
    logic       ep0_stall_hw;
    logic       ep0_accept;
    logic       ep2_stall_hw;
    logic       ep2_flip;
    logic       ep2_rdy_next;
    logic       ep2_rdy_reg;
    logic       grant_next;
    logic       grant_reg;
    logic       irq_out_n_n_reg;

    // Submodule state
    logic       ep0_ready;
    logic       ep0_stall;
    uec_stage_t ep0_stage;
    logic       ep0_lock;
    logic       ep0_pkt;
    logic       ep0_rd_dir;
    logic       ep2_cfg;
    logic       ep2_stall;
    logic       ep2_dir;
    logic       ep2_tgl;
    logic [6:0] ep2_pld;

    // A write is taken once, on the first cycle the strobe is seen low
    assign wr_act = !CS_N && !WR_N;
    assign wr_stb = wr_act && !wr_prev_reg;
    assign rd_act = !CS_N && !RD_N;

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            wr_prev_reg <= 1'b0;
        end else begin
            wr_prev_reg <= wr_act;
        end
    end

    always_comb begin
        wr_scratch = 1'b0;
        wr_ep0     = 1'b0;
        wr_ep2c    = 1'b0;
        wr_tgl     = 1'b0;
        wr_pld     = 1'b0;
        if (!wr_stb) begin
            wr_scratch = 1'b0;
        end else if (ADDR == `UEC_WR_EP0_SCRATCH) begin
            wr_scratch = 1'b1;
        end else if (ADDR == `UEC_WR_EP0_STATUS) begin
            wr_ep0 = 1'b1;
        end else if (ADDR == `UEC_WR_EP2_CONTROL) begin
            wr_ep2c = 1'b1;
        end else if (ADDR == `UEC_WR_EP2_TOGGLE) begin
            wr_tgl = 1'b1;
        end else if (ADDR == `UEC_WR_EP2_MAXPKT) begin
            wr_pld = 1'b1;
        end
    end

    // Scratch has no effect on anything else in the block
    always_ff @(posedge CLK) begin
        if (!RESET_N || USB_BUS_RESET) begin
            scratch_reg <= `UEC_SCRATCH_RST;
        end else if (wr_scratch) begin
            scratch_reg <= DATA_IN[6:0];
        end
    end

    always_comb begin
        rd_data = 8'h00;
        if (ADDR == `UEC_RD_EP0_SCRATCH) begin
            rd_data = {1'b0, scratch_reg};
        end else if (ADDR == `UEC_RD_EP0_STATUS) begin
            rd_data = {3'b000, 2'(ep0_stage), ep0_stall, 1'b0, ep0_ready};
        end else if (ADDR == `UEC_RD_EP2_CONTROL) begin
            rd_data = {ep2_cfg, `UEC_EP2_FIXED, ep2_stall, ep2_dir};
        end else if (ADDR == `UEC_RD_EP2_TOGGLE) begin
            rd_data = {7'h00, ep2_tgl};
        end else if (ADDR == `UEC_RD_EP2_MAXPKT) begin
            rd_data = {1'b0, ep2_pld};
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            data_out_reg <= 8'h00;
            data_oe_reg  <= 1'b0;
        end else begin
            data_out_reg <= rd_act ? rd_data : 8'h00;
            data_oe_reg  <= rd_act;
        end
    end

    // Endpoint of the OUT transaction in progress
    always_ff @(posedge CLK) begin
        if (!RESET_N || USB_BUS_RESET) begin
            cur_ep_reg  <= `UEC_EP0_NUM;
            cur_out_reg <= 1'b0;
        end else if (TOK_OUT) begin
            cur_ep_reg  <= TOK_EP;
            cur_out_reg <= 1'b1;
        end else if (TOK_IN || TOK_SETUP || RX_EOP || RX_NO_EOP) begin
            cur_out_reg <= 1'b0;
        end
    end

    // Saturates at 7F so a runaway packet reads as oversize, except on endpoint 2 with a limit of 7F
    always_ff @(posedge CLK) begin
        if (!RESET_N || USB_BUS_RESET) begin
            cnt_reg <= 7'h00;
        end else if (TOK_OUT) begin
            cnt_reg <= 7'h00;
        end else if (RX_BYTE && cur_out_reg && cnt_reg != `UEC_CNT_SAT) begin
            cnt_reg <= cnt_reg + 7'h01;
        end
    end

    assign ep0_over = cnt_reg > `UEC_EP0_MAX_SIZE;
    assign ep2_over = cnt_reg > ep2_pld;
    assign ep0_ctl_wr_data = (ep0_stage == UEC_STG_DATA) && !ep0_rd_dir;
    assign ep2_on = ep2_cfg;

    always_comb begin
        hs_valid_next = 1'b0;
        hs_code_next  = UEC_HS_ACK;
        ep0_stall_hw  = 1'b0;
        ep0_accept    = 1'b0;
        ep2_stall_hw  = 1'b0;
        ep2_flip      = 1'b0;
        ep2_rdy_next  = 1'b0;
        grant_next    = 1'b0;
        if (cur_out_reg && RX_NO_EOP) begin
            if (cur_ep_reg == `UEC_EP0_NUM && ep0_ctl_wr_data) begin
                ep0_stall_hw = 1'b1;
            end
        end else if (cur_out_reg && RX_EOP) begin
            if (cur_ep_reg == `UEC_EP0_NUM) begin
                hs_valid_next = 1'b1;
                if (ep0_ctl_wr_data && ep0_over) begin
                    ep0_stall_hw = 1'b1;
                    hs_code_next = UEC_HS_STALL;
                end else if (ep0_stall) begin
                    hs_code_next = UEC_HS_STALL;
                end else if (ep0_lock) begin
                    hs_code_next = UEC_HS_NAK;
                end else begin
                    ep0_accept = 1'b1;
                end
            end else if (cur_ep_reg == `UEC_EP2_NUM && ep2_on && !ep2_dir) begin
                hs_valid_next = 1'b1;
                if (ep2_stall || ep2_over) begin
                    ep2_stall_hw = ep2_over;
                    hs_code_next = UEC_HS_STALL;
                end else begin
                    ep2_rdy_next = 1'b1;
                    ep2_flip     = 1'b1;
                end
            end
        end else if (TOK_IN) begin
            if (TOK_EP == `UEC_EP0_NUM && ep0_stall) begin
                hs_valid_next = 1'b1;
                hs_code_next  = UEC_HS_STALL;
            end else if (TOK_EP == `UEC_EP2_NUM && ep2_on && ep2_dir) begin
                if (ep2_stall) begin
                    hs_valid_next = 1'b1;
                    hs_code_next  = UEC_HS_STALL;
                end else begin
                    grant_next = 1'b1;
                end
            end
        end else if (TX_ACKED && ep2_on && ep2_dir) begin
            ep2_flip = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N || USB_BUS_RESET) begin
            hs_valid_reg <= 1'b0;
            hs_code_reg  <= UEC_HS_ACK;
            ep2_rdy_reg  <= 1'b0;
            grant_reg    <= 1'b0;
        end else begin
            hs_valid_reg <= hs_valid_next;
            hs_code_reg  <= hs_code_next;
            ep2_rdy_reg  <= ep2_rdy_next;
            grant_reg    <= grant_next;
        end
    end

    // Only setup-ready reaches the pin; endpoint 2 events never do
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            irq_out_n_n_reg <= 1'b1;
        end else begin
            irq_out_n_n_reg <= !(ep0_ready && SETUP_INT_EN);
        end
    end

    uec_ep0_ctrl u_ep0 (
        .clk             (CLK),
        .rst_n           (RESET_N),
        .bus_rst         (USB_BUS_RESET),
        .setup_tok       (TOK_SETUP && TOK_EP == `UEC_EP0_NUM),
        .setup_ok        (SETUP_OK),
        .has_data        (SETUP_HAS_DATA),
        .dir_in          (SETUP_DIR_IN),
        .in_tok          (TOK_IN && TOK_EP == `UEC_EP0_NUM),
        .out_tok         (TOK_OUT && TOK_EP == `UEC_EP0_NUM),
        .rx_accept       (ep0_accept),
        .stall_set_hw    (ep0_stall_hw),
        .ready_clr_wr    (wr_ep0 && DATA_IN[`UEC_EP0_READY_BIT]),
        .stall_set_wr    (wr_ep0 && DATA_IN[`UEC_EP0_STALL_BIT]),
        .setup_ready_reg (ep0_ready),
        .stall_reg       (ep0_stall),
        .stage_reg       (ep0_stage),
        .lock_reg        (ep0_lock),
        .pkt_ready_reg   (ep0_pkt),
        .rd_dir_reg      (ep0_rd_dir)
    );

    uec_ep2_bulk u_ep2 (
        .clk        (CLK),
        .rst_n      (RESET_N),
        .bus_rst    (USB_BUS_RESET),
        .ctl_wr     (wr_ep2c),
        .tgl_wr     (wr_tgl),
        .pld_wr     (wr_pld),
        .wdata      (DATA_IN),
        .stall_hw   (ep2_stall_hw),
        .flip       (ep2_flip),
        .cfg_reg    (ep2_cfg),
        .stall_reg  (ep2_stall),
        .dir_reg    (ep2_dir),
        .toggle_reg (ep2_tgl),
        .pld_reg    (ep2_pld)
    );

    assign DATA_OUT         = data_out_reg;
    assign DATA_OE          = data_oe_reg;
    assign IRQ_OUT_N_N           = irq_out_n_n_reg;
    assign HS_VALID         = hs_valid_reg;
    assign HS_CODE          = 2'(hs_code_reg);
    assign EP0_PKT_READY    = ep0_pkt;
    assign EP0_RX_LOCKED    = ep0_lock;
    assign EP2_RX_PKT_READY = ep2_rdy_reg;
    assign EP2_IN_GRANT     = grant_reg;
    assign EP2_TOGGLE       = ep2_tgl;

endmodule

// File: uec_ep_ctrl_asserts.sv
module uec_ep_ctrl_asserts (
    // Clock and reset
    input wire logic       CLK,
    input wire logic       RESET_N,
    // Register bus
    input wire logic       CS_N,
    input wire logic       RD_N,
    input wire logic       WR_N,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] DATA_IN,
    input wire logic [7:0] DATA_OUT,
    // Interrupt, tokens and status
    input wire logic       SETUP_INT_EN,
    input wire logic       IRQ_OUT_N_N,
    input wire logic       TOK_SETUP,
    input wire logic       TOK_IN,
    input wire logic [3:0] TOK_EP,
    input wire logic       SETUP_OK,
    input wire logic       HS_VALID,
    input wire logic [1:0] HS_CODE,
    input wire logic       EP0_RX_LOCKED,
    input wire logic       EP2_RX_PKT_READY,
    input wire logic       EP2_TOGGLE
);
    timeunit 1ns;
    timeprecision 1ns;

    logic wr_low_reg;
    logic wr_take;

    // A write counts once, on the first edge of its strobe
    always_ff @(posedge CLK) begin
        wr_low_reg <= !CS_N && !WR_N;
    end
    assign wr_take = !CS_N && !WR_N && !wr_low_reg;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);

    property p_int_assert;
        SETUP_OK && SETUP_INT_EN ##1 SETUP_INT_EN |=> !IRQ_OUT_N_N;
    endproperty
    a_int_assert: assert property (p_int_assert)
        else $error("interrupt not raised after setup");

    property p_lock;
        SETUP_OK && !wr_take |=> EP0_RX_LOCKED;
    endproperty
    a_lock: assert property (p_lock)
        else $error("receive buffer not locked after setup");

    property p_int_release;
        wr_take && ADDR == 8'h73 && DATA_IN[0] && !SETUP_OK ##1 !SETUP_OK
            |-> !EP0_RX_LOCKED ##1 IRQ_OUT_N_N;
    endproperty
    a_int_release: assert property (p_int_release)
        else $error("clear of setup ready did not release");

    property p_stall_hs;
        wr_take && ADDR == 8'h73 && DATA_IN[2] ##1 !TOK_SETUP
            ##1 TOK_IN && TOK_EP == 4'h0 |=> HS_VALID && HS_CODE == 2'd2;
    endproperty
    a_stall_hs: assert property (p_stall_hs)
        else $error("forced stall not answered");

    property p_ready_ack;
        EP2_RX_PKT_READY |-> HS_VALID && HS_CODE == 2'd0;
    endproperty
    a_ready_ack: assert property (p_ready_ack)
        else $error("packet ready without acknowledge");

    property p_tgl_flip;
        EP2_RX_PKT_READY && !$past(wr_take) |-> EP2_TOGGLE != $past(EP2_TOGGLE);
    endproperty
    a_tgl_flip: assert property (p_tgl_flip)
        else $error("toggle did not alternate");

    property p_tgl_reset;
        wr_take && ADDR == 8'h75 && DATA_IN[0] |=> !EP2_TOGGLE;
    endproperty
    a_tgl_reset: assert property (p_tgl_reset)
        else $error("toggle not reset");

    property p_rd_stat;
        !CS_N && !RD_N && ADDR == 8'hF3 |=> (DATA_OUT & 8'hE2) == 8'h00;
    endproperty
    a_rd_stat: assert property (p_rd_stat)
        else $error("fixed status bits not zero");

    property p_rd_ctl;
        !CS_N && !RD_N && ADDR == 8'hF4 |=> DATA_OUT[6:2] == 5'h0A;
    endproperty
    a_rd_ctl: assert property (p_rd_ctl)
        else $error("fixed control bits wrong");

    c_setup: cover property (SETUP_OK);
    c_stall: cover property (HS_VALID && HS_CODE == 2'd2);
    c_pkt: cover property (EP2_RX_PKT_READY);
endmodule

bind uec_ep_ctrl_top uec_ep_ctrl_asserts u_uec_ep_ctrl_asserts (
    .CLK(CLK), .RESET_N(RESET_N), .CS_N(CS_N), .RD_N(RD_N), .WR_N(WR_N),
    .ADDR(ADDR), .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT),
    .SETUP_INT_EN(SETUP_INT_EN), .IRQ_OUT_N_N(IRQ_OUT_N_N), .TOK_SETUP(TOK_SETUP),
    .TOK_IN(TOK_IN), .TOK_EP(TOK_EP),
    .SETUP_OK(SETUP_OK), .HS_VALID(HS_VALID), .HS_CODE(HS_CODE),
    .EP0_RX_LOCKED(EP0_RX_LOCKED), .EP2_RX_PKT_READY(EP2_RX_PKT_READY),
    .EP2_TOGGLE(EP2_TOGGLE)
);

// File: uec_host_model.sv
module uec_host_model (
    // Clock
    input  wire logic  clk,
    // Tokens
    output logic       tok_setup,
    output logic       tok_in,
    output logic       tok_out,
    output logic [3:0] tok_ep,
    // Setup and packet events
    output logic       setup_ok,
    output logic       has_data,
    output logic       dir_in,
    output logic       rx_byte,
    output logic       rx_eop,
    output logic       rx_no_eop,
    output logic       tx_acked
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        {tok_setup, tok_in, tok_out, setup_ok, has_data, dir_in} = 6'h00;
        {rx_byte, rx_eop, rx_no_eop, tx_acked} = 4'h0;
        tok_ep = 4'hF;
    end

    // Kind 0 setup, 1 in, 2 out; endpoint field scrambled when idle
    task automatic token(input logic [1:0] kind, input logic [3:0] ep);
        {tok_setup, tok_in, tok_out} = {kind == 2'd0, kind == 2'd1, kind == 2'd2};
        tok_ep = ep;
        @(negedge clk);
        {tok_setup, tok_in, tok_out} = 3'b000;
        tok_ep = ~ep;
    endtask

    task automatic setup(input logic [3:0] ep, input logic data, input logic din);
        token(2'd0, ep);
        @(negedge clk);
        {setup_ok, has_data, dir_in} = {1'b1, data, din};
        @(negedge clk);
        {setup_ok, has_data, dir_in} = {1'b0, ~data, ~din};
    endtask

    task automatic out_pkt(input logic [3:0] ep, input int n, input logic good);
        token(2'd2, ep);
        rx_byte = 1'b1;
        repeat (n) @(negedge clk);
        {rx_byte, rx_eop, rx_no_eop} = {1'b0, good, !good};
        @(negedge clk);
        {rx_eop, rx_no_eop} = 2'b00;
    endtask

    task automatic ack_in;
        tx_acked = 1'b1;
        @(negedge clk);
        tx_acked = 1'b0;
    endtask
endmodule

// File: test_usb_ep0_status_ep2_bulk_ctrl.sv
module test_usb_ep0_status_ep2_bulk_ctrl;
    timeunit 1ns;
    timeprecision 1ns;

    logic       clk, reset_n, bus_rst, cs_n, rd_n, wr_n, doe, int_en, irq_out_n_n;
    logic       t_setup, t_in, t_out, s_ok, s_data, s_dir, rx_byte, rx_eop, rx_no_eop;
    logic       tx_acked, hs_valid, ep0_rdy, ep0_lock, ep2_rdy, ep2_grant, ep2_tgl;
    logic [7:0] addr, din, dout;
    logic [3:0] t_ep;
    logic [1:0] hs_code;
    int         n_mismatch = 0;
    int         cmp_count = 0;

    uec_ep_ctrl_top u_uec_ep_ctrl_top (
        .CLK(clk), .RESET_N(reset_n), .USB_BUS_RESET(bus_rst), .CS_N(cs_n), .RD_N(rd_n),
        .WR_N(wr_n), .ADDR(addr), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(doe),
        .SETUP_INT_EN(int_en), .IRQ_OUT_N_N(irq_out_n_n), .TOK_SETUP(t_setup), .TOK_IN(t_in),
        .TOK_OUT(t_out), .TOK_EP(t_ep), .SETUP_OK(s_ok), .SETUP_HAS_DATA(s_data),
        .SETUP_DIR_IN(s_dir), .RX_BYTE(rx_byte), .RX_EOP(rx_eop), .RX_NO_EOP(rx_no_eop),
        .TX_ACKED(tx_acked), .HS_VALID(hs_valid), .HS_CODE(hs_code),
        .EP0_PKT_READY(ep0_rdy), .EP0_RX_LOCKED(ep0_lock), .EP2_RX_PKT_READY(ep2_rdy),
        .EP2_IN_GRANT(ep2_grant), .EP2_TOGGLE(ep2_tgl)
    );

    uec_host_model u_uec_host_model (
        .clk(clk), .tok_setup(t_setup), .tok_in(t_in), .tok_out(t_out), .tok_ep(t_ep),
        .setup_ok(s_ok), .has_data(s_data), .dir_in(s_dir), .rx_byte(rx_byte),
        .rx_eop(rx_eop), .rx_no_eop(rx_no_eop), .tx_acked(tx_acked)
    );

    always #50 clk = ~clk;

    task automatic final_report;
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Bus tasks start and end on a falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        {cs_n, wr_n, addr, din} = {2'b00, a, d};
        @(negedge clk);
        {cs_n, wr_n} = 2'b11;
        @(negedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        {cs_n, rd_n, addr} = {2'b00, a};
        @(negedge clk);
        chk("read data", exp, dout);
        chk("read enable", 8'h01, {7'h00, doe});
        {cs_n, rd_n} = 2'b11;
        @(negedge clk);
    endtask

    task automatic hs(input logic v, input logic [1:0] code);
        chk("handshake", {5'h00, v, code}, {5'h00, hs_valid, v ? hs_code : 2'b00});
    endtask

    task automatic t_regs;
        rd(8'hF3, 8'h00);
        rd(8'hF4, 8'h28);
        rd(8'hF6, 8'h40);
        wr(8'h72, 8'hFF);
        rd(8'hF2, 8'h7F);
        wr(8'h76, 8'hFF);
        rd(8'hF6, 8'h7F);
        wr(8'h75, 8'hFE);
        rd(8'hF5, 8'h00);
        wr(8'h74, 8'h7F);
        rd(8'hF4, 8'h2B);
        wr(8'h73, 8'hE2);
        rd(8'hF3, 8'h00);
        wr(8'h77, 8'hFF);
        rd(8'hF7, 8'h00);
        wr(8'h74, 8'h00);
    endtask

    task automatic t_ep0;
        u_uec_host_model.setup(4'h0, 1'b1, 1'b0);
        chk("rx lock", 8'h01, {7'h00, ep0_lock});
        u_uec_host_model.out_pkt(4'h0, 2, 1'b1);
        hs(1'b1, 2'd1);
        rd(8'hF3, 8'h09);
        chk("interrupt", 8'h00, {7'h00, irq_out_n_n});
        wr(8'h73, 8'h00);
        rd(8'hF3, 8'h09);
        wr(8'h73, 8'h01);
        rd(8'hF3, 8'h08);
        chk("release", 8'h04, {5'h00, irq_out_n_n, ep0_lock, ep0_rdy});
        u_uec_host_model.out_pkt(4'h0, 8, 1'b1);
        hs(1'b1, 2'd0);
        chk("ep0 packet ready", 8'h01, {7'h00, ep0_rdy});
        u_uec_host_model.out_pkt(4'h0, 9, 1'b1);
        hs(1'b1, 2'd2);
        u_uec_host_model.token(2'd1, 4'h0);
        hs(1'b1, 2'd2);
        rd(8'hF3, 8'h14);
        int_en = 1'b0;
        u_uec_host_model.setup(4'h0, 1'b0, 1'b0);
        rd(8'hF3, 8'h11);
        chk("masked interrupt", 8'h01, {7'h00, irq_out_n_n});
        wr(8'h73, 8'h05);
        u_uec_host_model.token(2'd1, 4'h0);
        hs(1'b1, 2'd2);
    endtask

    task automatic t_ep2;
        u_uec_host_model.out_pkt(4'h2, 4, 1'b1);
        chk("unconfigured", 8'h00, {6'h00, hs_valid, ep2_rdy});
        wr(8'h74, 8'h80);
        wr(8'h75, 8'h01);
        chk("toggle", 8'h00, {7'h00, ep2_tgl});
        wr(8'h76, 8'h08);
        u_uec_host_model.out_pkt(4'h2, 8, 1'b1);
        hs(1'b1, 2'd0);
        chk("ready and toggle", 8'h03, {6'h00, ep2_rdy, ep2_tgl});
        u_uec_host_model.out_pkt(4'h2, 9, 1'b1);
        hs(1'b1, 2'd2);
        chk("oversize ready", 8'h00, {7'h00, ep2_rdy});
        rd(8'hF4, 8'hAA);
        u_uec_host_model.out_pkt(4'h2, 2, 1'b1);
        hs(1'b1, 2'd2);
        chk("stalled ready", 8'h00, {7'h00, ep2_rdy});
        wr(8'h74, 8'h81);
        wr(8'h75, 8'h01);
        u_uec_host_model.token(2'd1, 4'h2);
        chk("in grant", 8'h01, {7'h00, ep2_grant});
        u_uec_host_model.ack_in();
        chk("toggle", 8'h01, {7'h00, ep2_tgl});
        u_uec_host_model.out_pkt(4'h2, 2, 1'b1);
        chk("wrong direction", 8'h00, {6'h00, hs_valid, ep2_rdy});
        bus_rst = 1'b1;
        @(negedge clk);
        bus_rst = 1'b0;
        rd(8'hF4, 8'h28);
        rd(8'hF6, 8'h40);
    endtask

    initial begin
        {clk, reset_n, bus_rst, int_en} = 4'b0001;
        {cs_n, rd_n, wr_n, addr, din} = {3'b111, 16'h0000};
        repeat (4) @(negedge clk);
        reset_n = 1'b1;
        t_regs();
        t_ep0();
        t_ep2();
        final_report();
    end

    initial begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        final_report();
    end
endmodule
